// ==== verilog/ubwdc_top.sv ====
// break length, break detection, receiver activity and wide-data control
// assumes a baud core supplying bit ticks, receive events and the tx bit
// Function
// - Without long break, a sent break lasts 10 to 13 bit times by data format.
// - With long break, a sent break lasts 13 to 16 bit times by data format.
// - Long break never alters framing checks and should change only with tx off.
// - Without break detect enable, a break is seen after 10 to 13 bit times.
// - With break detect enable, a break is seen after 11, 12, 14 or 15 bit times.
// - While break detect is enabled, framing error and rx full flags cannot set.
// - Receiver active sets on a valid start bit and clears on an idle line.
// - In nine-bit mode rx bit 8 reads at control three bit 7, read before data.
// - In nine-bit mode a data write loads tx bit 8 from control three bit 6.
// - In ten-bit mode a data write loads tx bits 9 and 8 from control three.
// - In ten-bit mode rx bit 9 reads at control three bit 6, read before data.
// - Upper tx bits keep their values across data writes.
// - Control three holds upper bits, direction, inversion and four enables, reset 0.
// - A detected break with detect enabled sets a flag cleared by writing 1.
// - In single-wire mode the direction bit makes the tx pin input or output.
`timescale 1ns/1ns
`include "ubwdc_consts.svh"

module ubwdc_top #(
  parameter int CW = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core format and mode
  input wire ubwdc_pkg::ubwdc_fmt_t fmt,
  input wire logic tx_enable,
  input wire logic loopback_select,
  input wire logic receiver_source_select,
  input wire logic rx_invert,
  // baud timing
  input wire logic bit_tick,
  // receive events from the core shifter
  input wire logic rx_pin,
  input wire logic rx_start_seen,
  input wire logic rx_idle_seen,
  input wire logic rx_word_valid,
  input wire logic [9:0] rx_word,
  input wire logic rx_frame_err,
  // gated flag sets toward the core status
  output logic framing_error_flag_set,
  output logic rx_buffer_full_flag_set,
  output logic data_read_pulse,
  // transmit side
  input wire logic break_request,
  input wire logic tx_core_bit,
  output ubwdc_pkg::ubwdc_tx_t tx_buf,
  output logic break_active,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  // interrupt enables toward the core
  output logic overrun_irq_enable,
  output logic noise_irq_enable,
  output logic framing_irq_enable,
  output logic parity_irq_enable
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (CW < 5)
  begin : g_bad_cw
    $error("ubwdc_top: CW must hold a 16 bit-time count");
  end

  // ************************************************************
  // format decode
  // ************************************************************

  // 0: 8 data 1 stop, 1: one extra bit, 2: two extra, 3: ten-bit with 2 stop
  function automatic logic [1:0] fmt_index(input ubwdc_pkg::ubwdc_fmt_t f);
    if (f.ten_bit_select)
      fmt_index = f.stop_bit_count_select ? 2'h3 : 2'h2;
    else if (f.nine_bit_select && f.stop_bit_count_select)
      fmt_index = 2'h2;
    else if (f.nine_bit_select || f.stop_bit_count_select)
      fmt_index = 2'h1;
    else
      fmt_index = 2'h0;
  endfunction : fmt_index

  wire logic [1:0] fidx;
  assign fidx = fmt_index(fmt);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctl3_r;
  logic [1:0] rx_hi_r;
  logic [7:0] rx_lo_r;
  logic long_break_select_r;
  logic break_detect_enable_r;
  logic receiver_active_flag_r;
  logic break_detect_irq_flag_r;
  logic [7:0] rdata_r;
  ubwdc_pkg::ubwdc_tx_t tx_buf_r;

  wire logic wr_ctl3;
  wire logic wr_stat2;
  wire logic wr_data;
  wire logic rd_data;
  wire logic [7:0] ctl3_view;
  wire logic [7:0] stat2_view;
  wire logic [7:0] rd_mux;

  // address decode
  assign wr_ctl3 = reg_wr && (reg_addr == `UBWDC_OFS_CONTROL_THREE);
  assign wr_stat2 = reg_wr && (reg_addr == `UBWDC_OFS_STATUS_TWO);
  assign wr_data = reg_wr && (reg_addr == `UBWDC_OFS_DATA);
  assign rd_data = reg_rd && (reg_addr == `UBWDC_OFS_DATA);

  // control three read view: received upper bits replace the tx bits
  assign ctl3_view = {rx_hi_r[0], rx_hi_r[1], ctl3_r[5:0]};

  // status two read view, unused bits read zero
  assign stat2_view = {break_detect_irq_flag_r, 4'h0, long_break_select_r,
                       break_detect_enable_r, receiver_active_flag_r};

  // read select, unmapped offsets read zero
  assign rd_mux = (reg_addr == `UBWDC_OFS_CONTROL_THREE) ? ctl3_view :
                  (reg_addr == `UBWDC_OFS_STATUS_TWO) ? stat2_view :
                  (reg_addr == `UBWDC_OFS_DATA) ? rx_lo_r : 8'h00;

  // read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_r;
  assign data_read_pulse = rd_data;

  // control three storage; tx upper bits persist between data writes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctl3_r <= `UBWDC_C3_RESET;
    else if (wr_ctl3)
      ctl3_r <= reg_wdata;
  end

  assign overrun_irq_enable = ctl3_r[`UBWDC_C3_OVERRUN_IRQ_ENABLE];
  assign noise_irq_enable = ctl3_r[`UBWDC_C3_NOISE_IRQ_ENABLE];
  assign framing_irq_enable = ctl3_r[`UBWDC_C3_FRAMING_IRQ_ENABLE];
  assign parity_irq_enable = ctl3_r[`UBWDC_C3_PARITY_IRQ_ENABLE];

  // status two controls; long break is frozen while the transmitter runs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      long_break_select_r <= 1'b0;
      break_detect_enable_r <= 1'b0;
    end
    else if (wr_stat2)
    begin
      if (!tx_enable)
        long_break_select_r <= reg_wdata[`UBWDC_S2_LONG_BRK];
      break_detect_enable_r <= reg_wdata[`UBWDC_S2_BRK_DET_EN];
    end
  end

  // ************************************************************
  // transmit buffer load
  // ************************************************************
  wire logic [9:0] tx_word_nxt;

  // upper bits masked by the active data length
  assign tx_word_nxt = {ctl3_r[`UBWDC_C3_RX8_TX9] & fmt.ten_bit_select,
                        ctl3_r[`UBWDC_C3_RX9_TX8]
                          & (fmt.ten_bit_select | fmt.nine_bit_select),
                        reg_wdata};

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_buf_r <= '0;
    else
    begin
      tx_buf_r.load <= wr_data;
      if (wr_data)
        tx_buf_r.word <= tx_word_nxt;
    end
  end

  assign tx_buf = tx_buf_r;

  // ************************************************************
  // receive side
  // ************************************************************
  wire logic line_low;
  wire logic brk_found;
  wire logic [4:0] det_len;
  wire logic [4:0] det_short;
  wire logic [4:0] det_long;

  // line level after optional inversion
  assign line_low = (rx_pin ^ rx_invert) == 1'b0;

  // detection length tables
  assign det_short = (fidx == 2'h0) ? `UBWDC_DET_SHORT_0 :
                     (fidx == 2'h1) ? `UBWDC_DET_SHORT_1 :
                     (fidx == 2'h2) ? `UBWDC_DET_SHORT_2 : `UBWDC_DET_SHORT_3;
  assign det_long = (fidx == 2'h0) ? `UBWDC_DET_LONG_0 :
                    (fidx == 2'h1) ? `UBWDC_DET_LONG_1 :
                    (fidx == 2'h2) ? `UBWDC_DET_LONG_2 : `UBWDC_DET_LONG_3;
  assign det_len = break_detect_enable_r ? det_long : det_short;

  ubwdc_brk_det #(
    .CW(CW)
  ) u_brk_det (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bit_tick(bit_tick),
    .line_low(line_low),
    .det_len(CW'(det_len)),
    .found(brk_found)
  );

  // flag sets blocked while break detection is on; long break plays no part
  assign framing_error_flag_set = rx_frame_err && !break_detect_enable_r;
  assign rx_buffer_full_flag_set = rx_word_valid && !break_detect_enable_r;

  // receiver active: set wins over the idle clear
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      receiver_active_flag_r <= 1'b0;
    else if (rx_start_seen)
      receiver_active_flag_r <= 1'b1;
    else if (rx_idle_seen)
      receiver_active_flag_r <= 1'b0;
  end

  // break flag: set by detection, cleared by writing one, set wins
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      break_detect_irq_flag_r <= 1'b0;
    else if (brk_found && break_detect_enable_r)
      break_detect_irq_flag_r <= 1'b1;
    else if (wr_stat2 && reg_wdata[`UBWDC_S2_BRK_IRQ])
      break_detect_irq_flag_r <= 1'b0;
  end

  // received word capture; upper bits land in control three read view
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_lo_r <= 8'h00;
      rx_hi_r <= 2'h0;
    end
    else if (rx_buffer_full_flag_set)
    begin
      rx_lo_r <= rx_word[7:0];
      rx_hi_r <= {rx_word[9] & fmt.ten_bit_select, rx_word[8]};
    end
  end

  // ************************************************************
  // transmit break sequencer
  // ************************************************************
  ubwdc_pkg::ubwdc_txst_t txst_r;
  ubwdc_pkg::ubwdc_txst_t txst_nxt;
  logic [4:0] brk_cnt_r;
  logic [4:0] brk_cnt_nxt;
  wire logic [4:0] brk_len;
  wire logic brk_done;

  // base length plus the format index
  assign brk_len = (long_break_select_r ? `UBWDC_TX_BRK_LONG : `UBWDC_TX_BRK_SHORT)
                   + {3'h0, fidx};
  assign brk_cnt_nxt = brk_cnt_r + 5'h01;
  assign brk_done = bit_tick && (brk_cnt_nxt == brk_len);

  // next state
  always_comb
  begin
    txst_nxt = txst_r;
    unique case (txst_r)
      ubwdc_pkg::UBWDC_TX_IDLE:
        if (break_request && tx_enable)
          txst_nxt = ubwdc_pkg::UBWDC_TX_BREAK;
      ubwdc_pkg::UBWDC_TX_BREAK:
        if (brk_done || !tx_enable)
          txst_nxt = ubwdc_pkg::UBWDC_TX_IDLE;
      default:
        txst_nxt = ubwdc_pkg::UBWDC_TX_IDLE;
    endcase
  end

  // state and bit-time counter
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txst_r <= ubwdc_pkg::UBWDC_TX_IDLE;
      brk_cnt_r <= 5'h00;
    end
    else
    begin
      txst_r <= txst_nxt;
      if (txst_r != ubwdc_pkg::UBWDC_TX_BREAK)
        brk_cnt_r <= 5'h00;
      else if (bit_tick)
        brk_cnt_r <= brk_cnt_nxt;
    end
  end

  assign break_active = (txst_r == ubwdc_pkg::UBWDC_TX_BREAK);

  // ************************************************************
  // transmit pin
  // ************************************************************
  wire logic single_wire;

  // break forces space before inversion
  assign tx_pin_out = (break_active ? 1'b0 : tx_core_bit) ^ ctl3_r[`UBWDC_C3_TX_INVERT];
  assign single_wire = loopback_select && receiver_source_select;
  assign tx_pin_oe = single_wire ? ctl3_r[`UBWDC_C3_DIR] : 1'b1;

  // ************************************************************
  // checks
  // ************************************************************
  logic [4:0] low_ticks_r;

  // bit ticks spent in the current break, for the length checks
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_ticks_r <= 5'h00;
    else if (!break_active)
      low_ticks_r <= 5'h00;
    else if (bit_tick)
      low_ticks_r <= low_ticks_r + 5'h01;
  end

  a_brk_short_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(break_active) && tx_enable && !long_break_select_r
      |-> low_ticks_r == `UBWDC_TX_BRK_SHORT + {3'h0, fidx})
    else $error("short break length wrong");

  a_brk_long_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(break_active) && tx_enable && long_break_select_r
      |-> low_ticks_r == `UBWDC_TX_BRK_LONG + {3'h0, fidx})
    else $error("long break length wrong");

  a_lbs_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_enable && $past(tx_enable) |-> $stable(long_break_select_r))
    else $error("long break select moved with transmitter on");

  a_det_len_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    det_len == (break_detect_enable_r ? det_long : det_short)
      && det_long > det_short - 5'h01)
    else $error("detection length selection wrong");

  a_flags_blocked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    break_detect_enable_r |-> !framing_error_flag_set && !rx_buffer_full_flag_set)
    else $error("flag set while break detection enabled");

  a_rx_active_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_start_seen |=> receiver_active_flag_r)
    else $error("receiver active not set on start");

  a_rx_active_clr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_idle_seen && !rx_start_seen |=> !receiver_active_flag_r)
    else $error("receiver active not cleared on idle");

  a_tx_word_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_data |=> tx_buf.load && tx_buf.word[7:0] == $past(reg_wdata)
      && tx_buf.word[8] == ($past(ctl3_r[6]) && ($past(fmt.nine_bit_select)
      || $past(fmt.ten_bit_select))))
    else $error("transmit word not loaded from data and upper bits");

  a_rx_hi_view: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_buffer_full_flag_set |=> ctl3_view[7] == $past(rx_word[8]))
    else $error("received bit 8 not shown in control three");

  a_brk_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    brk_found && break_detect_enable_r |=> break_detect_irq_flag_r)
    else $error("break flag not set");

  a_single_wire_dir: assert property (@(posedge sys_clk) disable iff (sys_rst)
    single_wire |-> tx_pin_oe == ctl3_r[`UBWDC_C3_DIR])
    else $error("single-wire direction not honoured");

  c_tx_break: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(break_active) && tx_enable);
  c_break_found: cover property (@(posedge sys_clk) disable iff (sys_rst)
    brk_found && break_detect_enable_r);
  c_nine_bit_load: cover property (@(posedge sys_clk) disable iff (sys_rst)
    wr_data && fmt.nine_bit_select);
  c_flag_clear: cover property (@(posedge sys_clk) disable iff (sys_rst)
    break_detect_irq_flag_r ##1 !break_detect_irq_flag_r);

endmodule : ubwdc_top

// ==== verilog/ubwdc_consts.svh ====
// constants for the break and wide-data control block
// assumes inclusion by bare name from the top and break detector design files of the block
`ifndef UBWDC_CONSTS_SVH
`define UBWDC_CONSTS_SVH

// register offsets on the byte port
`define UBWDC_OFS_STATUS_TWO 3'h5
`define UBWDC_OFS_CONTROL_THREE 3'h6
`define UBWDC_OFS_DATA 3'h7

// control three field positions
`define UBWDC_C3_RX8_TX9 7
`define UBWDC_C3_RX9_TX8 6
`define UBWDC_C3_DIR 5
`define UBWDC_C3_TX_INVERT 4
`define UBWDC_C3_OVERRUN_IRQ_ENABLE 3
`define UBWDC_C3_NOISE_IRQ_ENABLE 2
`define UBWDC_C3_FRAMING_IRQ_ENABLE 1
`define UBWDC_C3_PARITY_IRQ_ENABLE 0
`define UBWDC_C3_RESET 8'h00

// status two field positions
`define UBWDC_S2_BRK_IRQ 7
`define UBWDC_S2_LONG_BRK 2
`define UBWDC_S2_BRK_DET_EN 1
`define UBWDC_S2_RX_ACTIVE 0
`define UBWDC_S2_RESET 8'h00

// break lengths in bit times
`define UBWDC_TX_BRK_SHORT 5'h0A
`define UBWDC_TX_BRK_LONG 5'h0D
`define UBWDC_DET_SHORT_0 5'h0A
`define UBWDC_DET_SHORT_1 5'h0B
`define UBWDC_DET_SHORT_2 5'h0C
`define UBWDC_DET_SHORT_3 5'h0D
`define UBWDC_DET_LONG_0 5'h0B
`define UBWDC_DET_LONG_1 5'h0C
`define UBWDC_DET_LONG_2 5'h0E
`define UBWDC_DET_LONG_3 5'h0F

`endif

// ==== verilog/ubwdc_pkg.sv ====
// types shared by the break and wide-data control block
// assumes nothing beyond a SystemVerilog compiler
package ubwdc_pkg;

  // data-format selects from the core control registers
  typedef struct packed {
    logic nine_bit_select;
    logic stop_bit_count_select;
    logic ten_bit_select;
  } ubwdc_fmt_t;

  // word handed to the transmit buffer
  typedef struct packed {
    logic load;
    logic [9:0] word;
  } ubwdc_tx_t;

  // transmit break sequencer
  typedef enum logic [1:0] {
    UBWDC_TX_IDLE = 2'b01,
    UBWDC_TX_BREAK = 2'b10
  } ubwdc_txst_t;

endpackage : ubwdc_pkg

// ==== verilog/ubwdc_brk_det.sv ====
// break detector: counts bit times while the receive line is low
// assumes bit_tick pulses once per bit time, phased to the start bit
`timescale 1ns/1ns
`include "ubwdc_consts.svh"

module ubwdc_brk_det #(
  parameter int CW = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // line and timing
  input wire logic bit_tick,
  input wire logic line_low,
  input wire logic [CW-1:0] det_len,
  // result
  output logic found
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (CW < 4)
  begin : g_bad_cw
    $error("ubwdc_brk_det: CW too small for break lengths");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic armed_r;
  logic found_r;
  wire logic reach;

  // one count per low bit time; disarm after a hit until the line idles
  assign cnt_nxt = cnt_r + CW'(1);
  assign reach = line_low && armed_r && bit_tick && (cnt_nxt == det_len);
  assign found = found_r;

  // counter runs from the start bit, cleared by any high level
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      armed_r <= 1'b1;
      found_r <= 1'b0;
    end
    else
    begin
      found_r <= reach;
      if (!line_low)
      begin
        cnt_r <= '0;
        armed_r <= 1'b1;
      end
      else if (bit_tick && armed_r)
      begin
        cnt_r <= reach ? '0 : cnt_nxt;
        armed_r <= !reach;
      end
    end
  end

  a_det_clear_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !line_low |=> cnt_r == '0)
    else $error("break counter not cleared by high line");

endmodule : ubwdc_brk_det

// ==== verif/ubwdc_station.sv ====
// remote serial station: paces bit times, holds the receive line low
// and measures how many bit times the transmit line stays low
// assumes the bench starts one low period at a time with go
`timescale 1ns/1ns

module ubwdc_station (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bench control
  input wire logic go,
  input wire logic [4:0] low_len,
  output logic busy,
  output logic [4:0] tx_low,
  // line side
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  output logic bit_tick,
  output logic rx_pin
);
  logic [1:0] div_r;
  logic [4:0] cnt_r;
  logic [4:0] run_r;
  logic tx_line;

  // one bit time is four clocks; a released tx line is pulled high
  assign bit_tick = div_r == 2'h3;
  assign tx_line = tx_pin_oe ? tx_pin_out : 1'b1;

  // rx low for low_len bit times, released two clocks after the last
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_r <= 2'h0;
      cnt_r <= 5'h00;
      busy <= 1'b0;
      rx_pin <= 1'b1;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (go)
      begin
        busy <= 1'b1;
        rx_pin <= 1'b0;
        cnt_r <= low_len;
      end
      else if (busy && bit_tick && cnt_r != 5'h00)
        cnt_r <= cnt_r - 5'h01;
      else if (busy && cnt_r == 5'h00 && div_r == 2'h1)
      begin
        busy <= 1'b0;
        rx_pin <= 1'b1;
      end
    end
  end

  // count bit times while the tx line is low, latch on its return high
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_r <= 5'h00;
      tx_low <= 5'h00;
    end
    else if (!tx_line && bit_tick)
      run_r <= run_r + 5'h01;
    else if (tx_line && run_r != 5'h00)
    begin
      tx_low <= run_r;
      run_r <= 5'h00;
    end
  end
endmodule : ubwdc_station

// ==== verif/testbench.sv ====
// bench for the break and wide-data control block
// assumes the design files and the station model are compiled first
`timescale 1ns/1ns

module testbench;
  logic sys_clk, sys_rst, reg_wr, reg_rd, tx_enable, loopback_select;
  logic receiver_source_select, rx_invert, bit_tick, rx_pin, rx_start_seen;
  logic rx_idle_seen, rx_word_valid, rx_frame_err, fe_set, full_set;
  logic break_request, tx_core_bit, break_active, tx_pin_out, tx_pin_oe;
  logic or_en, ne_en, fe_en, pe_en, go, busy, rd_pulse;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [9:0] rx_word;
  logic [4:0] low_len, tx_low;
  ubwdc_pkg::ubwdc_fmt_t fmt;
  ubwdc_pkg::ubwdc_tx_t tx_buf;
  int error_cnt, compares, i, k;
  logic [2:0] fmt_tab [4] = '{3'h0, 3'h4, 3'h6, 3'h3};
  logic [4:0] det_tab [4] = '{5'h0B, 5'h0C, 5'h0E, 5'h0F};

  // ****************************************
  // instances
  // ****************************************
  ubwdc_top ubwdc_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fmt(fmt),
    .tx_enable(tx_enable), .loopback_select(loopback_select),
    .receiver_source_select(receiver_source_select),
    .rx_invert(rx_invert), .bit_tick(bit_tick), .rx_pin(rx_pin),
    .rx_start_seen(rx_start_seen), .rx_idle_seen(rx_idle_seen),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_frame_err(rx_frame_err), .framing_error_flag_set(fe_set),
    .rx_buffer_full_flag_set(full_set), .data_read_pulse(rd_pulse),
    .break_request(break_request), .tx_core_bit(tx_core_bit),
    .tx_buf(tx_buf), .break_active(break_active), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .overrun_irq_enable(or_en),
    .noise_irq_enable(ne_en), .framing_irq_enable(fe_en),
    .parity_irq_enable(pe_en));

  ubwdc_station ubwdc_station_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .go(go), .low_len(low_len), .busy(busy), .tx_low(tx_low),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .bit_tick(bit_tick),
    .rx_pin(rx_pin));

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    #1;
    chk("rd_pulse", {9'h0, a == 3'h7}, {9'h0, rd_pulse});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, {2'h0, e}, {2'h0, reg_rdata});
  endtask : rd

  // data write, then the word handed to the transmit buffer
  task automatic txw(input logic [7:0] d, input logic [9:0] e);
    wr(3'h7, d);
    chk("tx_load", 10'h001, {9'h0, tx_buf.load});
    chk("tx_word", e, tx_buf.word);
  endtask : txw

  // received word with a framing error; e is whether flags may set
  task automatic rxw(input logic [9:0] w, input logic e);
    @(posedge sys_clk);
    rx_word_valid <= 1'b1;
    rx_frame_err <= 1'b1;
    rx_word <= w;
    #1;
    chk("flag_sets", {8'h0, e, e}, {8'h0, fe_set, full_set});
    @(posedge sys_clk);
    rx_word_valid <= 1'b0;
    rx_frame_err <= 1'b0;
    #1;
  endtask : rxw

  // station holds the receive line low for n bit times
  task automatic brk(input logic [4:0] n);
    @(posedge sys_clk);
    go <= 1'b1;
    low_len <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 300 && busy; k++)
      @(posedge sys_clk);
    if (busy)
    begin
      error_cnt++;
      give_verdict();
    end
    repeat (3) @(posedge sys_clk);
  endtask : brk

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    {sys_rst, tx_core_bit} = 2'h3;
    {reg_wr, reg_rd, tx_enable, loopback_select, receiver_source_select} = 5'h0;
    {rx_invert, rx_start_seen, rx_idle_seen, rx_word_valid} = 4'h0;
    {rx_frame_err, break_request, go} = 3'h0;
    {reg_addr, reg_wdata, rx_word, low_len} = 26'h0;
    fmt = 3'h0;
    error_cnt = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(3'h6, 8'h00, "ctl3");
    rd(3'h5, 8'h00, "status");
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'h00, "unmapped");
    wr(3'h6, 8'h3A);
    rd(3'h6, 8'h3A, "ctl3");
    chk("irq_en", 10'h00A, {6'h0, or_en, ne_en, fe_en, pe_en});
    chk("tx_inv", 10'h000, {9'h0, tx_pin_out});
    {loopback_select, receiver_source_select} <= 2'h3;
    wr(3'h6, 8'h00);
    chk("tx_oe", 10'h000, {9'h0, tx_pin_oe});
    wr(3'h6, 8'h20);
    chk("tx_oe", 10'h001, {9'h0, tx_pin_oe});
    {loopback_select, receiver_source_select} <= 2'h0;
    fmt <= 3'h4;
    wr(3'h6, 8'h40);
    txw(8'hA5, 10'h1A5);
    txw(8'h5A, 10'h15A);
    wr(3'h6, 8'hC0);
    txw(8'h00, 10'h100);
    fmt <= 3'h1;
    txw(8'h33, 10'h333);
    rxw(10'h2C3, 1'b1);
    rd(3'h6, 8'h40, "ctl3");
    rd(3'h7, 8'hC3, "data");
    fmt <= 3'h4;
    rxw(10'h1A5, 1'b1);
    rd(3'h6, 8'h80, "ctl3");
    rd(3'h7, 8'hA5, "data");
    wr(3'h5, 8'h02);
    rxw(10'h0FF, 1'b0);
    rd(3'h7, 8'hA5, "data");
    rx_start_seen <= 1'b1;
    @(posedge sys_clk);
    rx_start_seen <= 1'b0;
    rd(3'h5, 8'h03, "status");
    rx_idle_seen <= 1'b1;
    @(posedge sys_clk);
    rx_idle_seen <= 1'b0;
    rd(3'h5, 8'h02, "status");
    for (i = 0; i < 4; i++)
    begin
      fmt <= ubwdc_pkg::ubwdc_fmt_t'(fmt_tab[i]);
      brk(det_tab[i] - 5'h01);
      rd(3'h5, 8'h02, "brk_flag");
      brk(det_tab[i]);
      rd(3'h5, 8'h82, "brk_flag");
      wr(3'h5, 8'h82);
      rd(3'h5, 8'h02, "brk_flag");
    end
    // inverted idle line reads as low, so a break is seen
    rx_invert <= 1'b1;
    repeat (70) @(posedge sys_clk);
    rx_invert <= 1'b0;
    rd(3'h5, 8'h82, "inv_brk");
    wr(3'h5, 8'h80);
    for (i = 0; i < 8; i++)
    begin
      tx_enable <= 1'b0;
      fmt <= ubwdc_pkg::ubwdc_fmt_t'(fmt_tab[i % 4]);
      wr(3'h5, (i < 4) ? 8'h00 : 8'h04);
      tx_enable <= 1'b1;
      @(posedge sys_clk);
      break_request <= 1'b1;
      @(posedge sys_clk);
      break_request <= 1'b0;
      #1;
      for (k = 0; k < 400 && break_active; k++)
        @(posedge sys_clk);
      if (break_active)
      begin
        error_cnt++;
        give_verdict();
      end
      repeat (2) @(posedge sys_clk);
      chk("brk_len", 10'((i < 4) ? 10 + i : 9 + i), {5'h0, tx_low});
    end
    tx_enable <= 1'b0;
    wr(3'h5, 8'h00);
    tx_enable <= 1'b1;
    wr(3'h5, 8'h04);
    rd(3'h5, 8'h00, "status");
    give_verdict();
  end
endmodule : testbench
